/* File: rtl/spc_map.svh */
// Numeric constants of the sector protection control block.
// Assumes inclusion by the package and the top module only.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Command opcodes, taken from the serial port
`define SPC_OP_WREN        8'h06
`define SPC_OP_WRDI        8'h04
`define SPC_OP_WRSR        8'h01
`define SPC_OP_PROTECT     8'h36
`define SPC_OP_UNPROTECT   8'h39
`define SPC_OP_READ_PROT   8'h3C

// Frame geometry
`define SPC_BYTE_BITS      3'h7
`define SPC_ADDR_BYTES     3'h4
`define SPC_WRSR_BYTES     3'h2
`define SPC_OP_BYTES       3'h1
`define SPC_BYTES_MAX      3'h7

// Sector layout: seven big sectors, then 32K, 8K, 8K, 16K at the top
`define SPC_NUM_SECTORS    11
`define SPC_SEC_TOP_BIG    3'h7
`define SPC_SEC_HALF       4'h7
`define SPC_SEC_SMALL_A    4'h8
`define SPC_SEC_SMALL_B    4'h9
`define SPC_SEC_TOP        4'hA

// Status write fields
`define SPC_WR_LOCK_BIT    7
`define SPC_WR_GLOB_HI     5
`define SPC_WR_GLOB_LO     2
`define SPC_GLOB_ALL_ONE   4'hF
`define SPC_GLOB_ALL_ZERO  4'h0

// Summary encodings
`define SPC_SUM_NONE       2'h0
`define SPC_SUM_SOME       2'h1
`define SPC_SUM_ALL        2'h3

// Reset values
`define SPC_FLAGS_RST      11'h7FF
`define SPC_LOCK_RST       1'h0
`define SPC_WEL_RST        1'h0

`endif

/* File: rtl/spc_pkg.sv */
// Types shared by the sector protection control block.
// Assumes spc_map.svh is on the include path.
`include "spc_map.svh"

package spc_pkg;

	typedef logic [`SPC_NUM_SECTORS-1:0] spc_flags_t;
	typedef logic [3:0]                  spc_sector_t;

	typedef enum logic [7:0] {
		SPC_CMD_WRSR      = 8'h01,
		SPC_CMD_WRDI      = 8'h04,
		SPC_CMD_WREN      = 8'h06,
		SPC_CMD_PROTECT   = 8'h36,
		SPC_CMD_UNPROTECT = 8'h39,
		SPC_CMD_READ_PROT = 8'h3C
	} spc_op_e;

	// Snapshot of one serial frame, held static while select is high
	typedef struct packed {
		logic [7:0]  op;
		logic [23:0] addr;
		logic [7:0]  data;
		logic [2:0]  bits;
		logic [2:0]  bytes;
	} spc_cmd_s;

endpackage

/* File: rtl/spc_sync3.sv */
// Three-stage synchroniser; output moves once stages two and three agree.
// Assumes a synchronous active-low reset in the destination domain.
`timescale 1ns/1ps
`default_nettype none

module spc_sync3 #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= RST;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					q[i] <= s2_q[i];
				end
			end
		end
	end

endmodule

`default_nettype wire

/* File: rtl/spc_sector_protect.sv */
// Sector protection control: per-sector flags, lock bit, global decode, readback.
// Assumes a host in SPI mode 0 or 3; sck stands still while cs_n is high.
`timescale 1ns/1ps
`default_nettype none

`include "spc_map.svh"

module spc_sector_protect (
	// System clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Serial link
	input  wire logic                      sck,
	input  wire logic                      cs_n,
	input  wire logic                      si,
	output logic                           so_o,
	output logic                           so_oe,
	// Write protect pin
	input  wire logic                      wp_n,
	// Status
	output logic                           write_enable_latch,
	output logic                           protect_regs_locked,
	output logic [1:0]                     software_protect_summary,
	output spc_pkg::spc_flags_t            sector_flags
);

	function automatic spc_pkg::spc_sector_t sector_of(input logic [23:0] a);
		spc_pkg::spc_sector_t s;
		s = `SPC_SEC_TOP;
		if (a[18:16] != `SPC_SEC_TOP_BIG) begin
			s = {1'b0, a[18:16]};
		end else if (!a[15]) begin
			s = `SPC_SEC_HALF;
		end else if (a[14:13] == 2'h0) begin
			s = `SPC_SEC_SMALL_A;
		end else if (a[14:13] == 2'h1) begin
			s = `SPC_SEC_SMALL_B;
		end
		return s;
	endfunction

	// Link domain: frame capture on sck

	spc_pkg::spc_cmd_s cmd_q;
	logic [7:0]        sh_q;
	logic              live_q;
	logic              frame_tog_q;
	logic [2:0]        bit_n;
	logic [2:0]        byte_n;
	logic [7:0]        sh_n;
	logic [7:0]        new_byte;

	// Counters restart at the first edge of a frame, not at cs_n, so the
	// snapshot stays readable after the frame has ended
	always_comb begin
		bit_n  = live_q ? cmd_q.bits : 3'h0;
		byte_n = live_q ? cmd_q.bytes : 3'h0;
		sh_n   = live_q ? sh_q : 8'h00;
		new_byte = {sh_n[6:0], si};
	end

	// Async on cs_n: the frame ends with no further sck edge
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
		end
	end

	// Async rst_n here only because sck may not run during reset
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			frame_tog_q <= 1'b0;
		end else if (!live_q) begin
			frame_tog_q <= ~frame_tog_q;
		end
	end

	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			sh_q  <= 8'h00;
			cmd_q <= '0;
		end else begin
			sh_q       <= new_byte;
			cmd_q.bits <= 3'(bit_n + 3'h1);
			cmd_q.op   <= live_q ? cmd_q.op : 8'h00;
			cmd_q.addr <= live_q ? cmd_q.addr : 24'h000000;
			cmd_q.data <= live_q ? cmd_q.data : 8'h00;
			cmd_q.bytes <= byte_n;
			if (bit_n == `SPC_BYTE_BITS) begin
				if (byte_n != `SPC_BYTES_MAX) begin
					cmd_q.bytes <= 3'(byte_n + 3'h1);
				end
				if (byte_n == 3'h0) begin
					cmd_q.op <= new_byte;
				end
				if (byte_n == 3'h1) begin
					cmd_q.data <= new_byte;
				end
				if (byte_n != 3'h0 && byte_n < `SPC_ADDR_BYTES) begin
					cmd_q.addr <= {cmd_q.addr[15:0], new_byte};
				end
			end
		end
	end

	// Readback drive on falling sck; flags only change between frames, so
	// they are static while sampled here
	logic so_en_q;
	logic so_q;

	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			so_en_q <= 1'b0;
			so_q    <= 1'b0;
		end else begin
			so_en_q <= live_q && cmd_q.op == `SPC_OP_READ_PROT && cmd_q.bytes >= `SPC_ADDR_BYTES;
			so_q    <= sector_flags[sector_of(cmd_q.addr)];
		end
	end

	// Every bit of the repeating FFh/00h byte equals the flag
	assign so_o  = so_q;
	assign so_oe = so_en_q;

	// System domain: crossings

	logic cs_n_s;
	logic wp_n_s;
	logic tog_s;
	logic cs_n_d1_q;
	logic seen_tog_q;
	logic frame_end;

	spc_sync3 #(.W(3), .RST(3'b110)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({cs_n, wp_n, frame_tog_q}),
		.q     ({cs_n_s, wp_n_s, tog_s})
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_n_d1_q  <= 1'b1;
			seen_tog_q <= 1'b0;
		end else begin
			cs_n_d1_q <= cs_n_s;
			if (frame_end) begin
				seen_tog_q <= tog_s;
			end
		end
	end

	// A select pulse with no sck edge is not a frame
	assign frame_end = cs_n_s && !cs_n_d1_q && (tog_s != seen_tog_q);

	// Command decode at end of frame

	logic aligned;
	logic is_prot;
	logic is_unprot;
	logic is_wrsr;
	logic sec_ok;
	logic wrsr_ok;
	logic hard_lock;
	logic glob_one;
	logic glob_zero;
	logic do_prot;
	logic do_unprot;
	logic do_lock_wr;
	logic do_glob_p;
	logic do_glob_u;
	spc_pkg::spc_sector_t sec;

	always_comb begin
		aligned    = (cmd_q.bits == 3'h0);
		is_prot    = frame_end && cmd_q.op == `SPC_OP_PROTECT;
		is_unprot  = frame_end && cmd_q.op == `SPC_OP_UNPROTECT;
		is_wrsr    = frame_end && cmd_q.op == `SPC_OP_WRSR;
		sec_ok     = aligned && cmd_q.bytes >= `SPC_ADDR_BYTES && write_enable_latch
		             && !protect_regs_locked;
		wrsr_ok    = is_wrsr && aligned && cmd_q.bytes >= `SPC_WRSR_BYTES && write_enable_latch;
		hard_lock  = protect_regs_locked && !wp_n_s;
		// Mixed patterns match neither, so flags stay as they are
		glob_one   = cmd_q.data[`SPC_WR_GLOB_HI:`SPC_WR_GLOB_LO] == `SPC_GLOB_ALL_ONE;
		glob_zero  = cmd_q.data[`SPC_WR_GLOB_HI:`SPC_WR_GLOB_LO] == `SPC_GLOB_ALL_ZERO;
		do_prot    = is_prot && sec_ok;
		do_unprot  = is_unprot && sec_ok;
		do_lock_wr = wrsr_ok && !hard_lock;
		do_glob_p  = wrsr_ok && !protect_regs_locked && glob_one;
		do_glob_u  = wrsr_ok && !protect_regs_locked && glob_zero;
		sec        = sector_of(cmd_q.addr);
	end

	// Write enable latch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			write_enable_latch <= `SPC_WEL_RST;
		end else if (frame_end) begin
			if (cmd_q.op == `SPC_OP_WREN && aligned && cmd_q.bytes >= `SPC_OP_BYTES) begin
				write_enable_latch <= 1'b1;
			end else if (cmd_q.op == `SPC_OP_WRDI && aligned && cmd_q.bytes >= `SPC_OP_BYTES) begin
				write_enable_latch <= 1'b0;
			end else if (is_prot || is_unprot || wrsr_ok) begin
				// Cleared on success, lock and protect/unprotect abort alike
				write_enable_latch <= 1'b0;
			end
		end
	end

	// Lock bit: only bit 7 of a status write is stored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			protect_regs_locked <= `SPC_LOCK_RST;
		end else if (do_lock_wr) begin
			protect_regs_locked <= cmd_q.data[`SPC_WR_LOCK_BIT];
		end
	end

	// Sector flags; globals use the lock value from before this write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sector_flags <= `SPC_FLAGS_RST;
		end else if (do_glob_p) begin
			sector_flags <= `SPC_FLAGS_RST;
		end else if (do_glob_u) begin
			sector_flags <= '0;
		end else if (do_prot) begin
			sector_flags[sec] <= 1'b1;
		end else if (do_unprot) begin
			sector_flags[sec] <= 1'b0;
		end
	end

	// Summary of all flags
	always_comb begin
		if (&sector_flags) begin
			software_protect_summary = `SPC_SUM_ALL;
		end else if (|sector_flags) begin
			software_protect_summary = `SPC_SUM_SOME;
		end else begin
			software_protect_summary = `SPC_SUM_NONE;
		end
	end

	// Checks

	property p_rst_state;
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> (&sector_flags) && !protect_regs_locked && !write_enable_latch;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("bad state after reset");

	property p_prot;
		@(posedge clk) disable iff (!rst_n)
		do_prot |=> sector_flags[$past(sec)] && !write_enable_latch;
	endproperty
	a_prot: assert property (p_prot) else $error("protect did not set flag");

	property p_unprot;
		@(posedge clk) disable iff (!rst_n)
		do_unprot |=> !sector_flags[$past(sec)] && !write_enable_latch;
	endproperty
	a_unprot: assert property (p_unprot) else $error("unprotect did not clear flag");

	property p_abort;
		@(posedge clk) disable iff (!rst_n)
		(is_prot || is_unprot) && !sec_ok |=> $stable(sector_flags) && !write_enable_latch;
	endproperty
	a_abort: assert property (p_abort) else $error("refused sector command changed state");

	property p_no_wel;
		@(posedge clk) disable iff (!rst_n)
		!write_enable_latch ##1 (is_prot || is_unprot || is_wrsr) |=> $stable(sector_flags);
	endproperty
	a_no_wel: assert property (p_no_wel) else $error("command ran without latch");

	property p_hard_lock;
		@(posedge clk) disable iff (!rst_n)
		frame_end && hard_lock |=> $stable(sector_flags) && protect_regs_locked;
	endproperty
	a_hard_lock: assert property (p_hard_lock) else $error("hard lock broken");

	property p_mixed;
		@(posedge clk) disable iff (!rst_n)
		wrsr_ok && !glob_one && !glob_zero |=> $stable(sector_flags);
	endproperty
	a_mixed: assert property (p_mixed) else $error("mixed bits changed flags");

	property p_soft_lock;
		@(posedge clk) disable iff (!rst_n)
		wrsr_ok && protect_regs_locked && wp_n_s |=> $stable(sector_flags)
			&& protect_regs_locked == $past(cmd_q.data[`SPC_WR_LOCK_BIT]);
	endproperty
	a_soft_lock: assert property (p_soft_lock) else $error("soft lock allowed global");

	property p_glob;
		@(posedge clk) disable iff (!rst_n)
		do_glob_p |=> (&sector_flags) && !write_enable_latch;
	endproperty
	a_glob: assert property (p_glob) else $error("global protect failed");

	property p_glob_u;
		@(posedge clk) disable iff (!rst_n)
		do_glob_u |=> (sector_flags == '0) && !write_enable_latch;
	endproperty
	a_glob_u: assert property (p_glob_u) else $error("global unprotect failed");

	property p_quiet;
		@(posedge clk) disable iff (!rst_n)
		!frame_end |=> $stable(sector_flags) && $stable(protect_regs_locked);
	endproperty
	a_quiet: assert property (p_quiet) else $error("state moved outside a frame end");

	property p_summary;
		@(posedge clk) disable iff (!rst_n)
		(software_protect_summary == `SPC_SUM_NONE) == (sector_flags == '0)
			&& (software_protect_summary == `SPC_SUM_ALL) == (&sector_flags)
			&& software_protect_summary != 2'h2;
	endproperty
	a_summary: assert property (p_summary) else $error("summary wrong");

	property p_readback;
		@(posedge sck) disable iff (!rst_n)
		so_oe |-> so_o == sector_flags[sector_of(cmd_q.addr)];
	endproperty
	a_readback: assert property (p_readback) else $error("readback not the flag");

endmodule

`default_nettype wire

/* File: tb/spc_host_model.sv */
// Host serial controller model: drives select, clock and data in mode 0.
// Assumes the device samples si on rising sck and moves so on falling sck.
`timescale 1ns/1ps
`default_nettype none

module spc_host_model (
	// Serial link
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so_o,
	input  wire logic so_oe
);
	localparam int HALF_NS = 15;
	localparam int GAP_NS  = 800;

	initial begin
		sck  = 1'b0;
		cs_n = 1'b1;
		si   = 1'b0;
	end

	// Sends n bits of d from the top down; returns so as sampled on rising sck
	task automatic xfer(input logic [47:0] d, input int n, output logic [47:0] rd);
		rd   = '0;
		cs_n = 1'b0;
		#HALF_NS;
		for (int i = 0; i < n; i++) begin
			si = d[47-i];
			#HALF_NS;
			sck = 1'b1;
			// Undriven line reads inverted, so a missing enable shows up
			rd  = {rd[46:0], so_oe ? so_o : ~so_o};
			#HALF_NS;
			sck = 1'b0;
		end
		#HALF_NS;
		cs_n = 1'b1;
		// Released line must not keep its last level
		si = ~si;
		// Clock stands still; gap lets the clk side see the frame end
		#GAP_NS;
	endtask
endmodule

`default_nettype wire

/* File: tb/spc_sector_protect_tb.sv */
// Self-checking bench for the sector protection control block.
// Assumes spc_pkg, spc_sync3, the design top and spc_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module spc_sector_protect_tb;
	typedef struct packed {
		logic                we;
		logic [47:0]         frame;
		logic [5:0]          n;
		spc_pkg::spc_flags_t flags;
		logic                lock;
		logic                latch;
	} spc_row_s;

	localparam int NROWS = 24;

	logic                clk;
	logic                rst_n;
	logic                wp_n;
	logic                sck;
	logic                cs_n;
	logic                si;
	logic                so_o;
	logic                so_oe;
	logic                write_enable_latch;
	logic                protect_regs_locked;
	logic [1:0]          software_protect_summary;
	spc_pkg::spc_flags_t sector_flags;
	logic [47:0]         rd;
	int                  num_errors;
	int                  comparisons;

	spc_row_s rows [0:NROWS-1] = '{
		'{1'b1, 48'h0100_0000_0000, 6'd16, 11'h000, 1'b0, 1'b0},
		'{1'b1, 48'h017F_0000_0000, 6'd16, 11'h7FF, 1'b0, 1'b0},
		'{1'b1, 48'h0100_0000_0000, 6'd16, 11'h000, 1'b0, 1'b0},
		'{1'b1, 48'h3600_0000_0000, 6'd32, 11'h001, 1'b0, 1'b0},
		'{1'b1, 48'h3607_A123_4A00, 6'd40, 11'h201, 1'b0, 1'b0},
		'{1'b1, 48'h0104_0000_0000, 6'd16, 11'h201, 1'b0, 1'b0},
		'{1'b1, 48'h0178_0000_0000, 6'd16, 11'h201, 1'b0, 1'b0},
		'{1'b1, 48'h3900_FFFF_0000, 6'd32, 11'h200, 1'b0, 1'b0},
		'{1'b0, 48'h3601_0000_0000, 6'd32, 11'h200, 1'b0, 1'b0},
		'{1'b1, 48'h3601_0000_0000, 6'd24, 11'h200, 1'b0, 1'b0},
		'{1'b1, 48'h3601_0000_0000, 6'd38, 11'h200, 1'b0, 1'b0},
		'{1'b1, 48'h01F0_0000_0000, 6'd16, 11'h200, 1'b1, 1'b0},
		'{1'b1, 48'h3601_0000_0000, 6'd32, 11'h200, 1'b1, 1'b0},
		'{1'b1, 48'h397A_0000_0000, 6'd32, 11'h200, 1'b1, 1'b0},
		'{1'b1, 48'h010F_0000_0000, 6'd16, 11'h200, 1'b0, 1'b0},
		'{1'b1, 48'h01FF_0000_0000, 6'd16, 11'h7FF, 1'b1, 1'b0},
		'{1'b1, 48'h0100_0000_0000, 6'd16, 11'h7FF, 1'b0, 1'b0},
		'{1'b0, 48'h0600_0000_0000, 6'd8,  11'h7FF, 1'b0, 1'b1},
		'{1'b0, 48'h0400_0000_0000, 6'd8,  11'h7FF, 1'b0, 1'b0},
		'{1'b0, 48'h0100_0000_0000, 6'd16, 11'h7FF, 1'b0, 1'b0},
		'{1'b1, 48'h0100_0000_0000, 6'd16, 11'h000, 1'b0, 1'b0},
		'{1'b1, 48'h367F_FFFF_0000, 6'd32, 11'h400, 1'b0, 1'b0},
		'{1'b1, 48'h3607_8000_0000, 6'd32, 11'h500, 1'b0, 1'b0},
		'{1'b1, 48'h36F7_0000_0000, 6'd32, 11'h580, 1'b0, 1'b0}
	};

	spc_sector_protect DUT (
		.clk                      (clk),
		.rst_n                    (rst_n),
		.sck                      (sck),
		.cs_n                     (cs_n),
		.si                       (si),
		.so_o                     (so_o),
		.so_oe                    (so_oe),
		.wp_n                     (wp_n),
		.write_enable_latch       (write_enable_latch),
		.protect_regs_locked      (protect_regs_locked),
		.software_protect_summary (software_protect_summary),
		.sector_flags             (sector_flags)
	);

	spc_host_model host (
		.sck   (sck),
		.cs_n  (cs_n),
		.si    (si),
		.so_o  (so_o),
		.so_oe (so_oe)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [1:0] sum_of(spc_pkg::spc_flags_t f);
		return (f == '0) ? 2'h0 : ((&f) ? 2'h3 : 2'h1);
	endfunction

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Flags, lock, latch, summary and released output against expectation
	task automatic check_state(input spc_pkg::spc_flags_t f, input logic lk, input logic wl);
		check(48'(sector_flags), 48'(f));
		check(48'(protect_regs_locked), 48'(lk));
		check(48'(write_enable_latch), 48'(wl));
		check(48'(software_protect_summary), 48'(sum_of(f)));
		check(48'(so_oe), 48'h0);
	endtask

	task automatic wren();
		host.xfer(48'h0600_0000_0000, 8, rd);
	endtask

	task automatic do_reset();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
	endtask

	task automatic tally_and_finish();
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#2ms;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		num_errors  = 0;
		comparisons = 0;
		rst_n       = 1'b0;
		wp_n        = 1'b1;
		rd          = '0;
		do_reset();
		check_state(11'h7FF, 1'b0, 1'b0);
		for (int r = 0; r < NROWS; r++) begin
			if (rows[r].we) begin
				wren();
			end
			host.xfer(rows[r].frame, int'(rows[r].n), rd);
			check_state(rows[r].flags, rows[r].lock, rows[r].latch);
		end
		// Readback of a protected and an unprotected sector
		host.xfer({8'h3C, 24'h070000, 16'h0}, 48, rd);
		check({32'h0, rd[15:0]}, 48'h0000_0000_FFFF);
		check(48'(so_oe), 48'h0);
		@(negedge clk);
		wp_n = 1'b0;
		host.xfer({8'h3C, 24'h000000, 16'h0}, 48, rd);
		check({32'h0, rd[15:0]}, 48'h0);
		// Select rises mid-byte during readback
		host.xfer({8'h3C, 24'h070000, 16'h0}, 36, rd);
		check({44'h0, rd[3:0]}, 48'h0000_0000_000F);
		check(48'(so_oe), 48'h0);
		// Hard lock: pin low and lock set freeze flags and lock
		wren();
		host.xfer(48'h01F0_0000_0000, 16, rd);
		check_state(11'h580, 1'b1, 1'b0);
		wren();
		host.xfer(48'h010F_0000_0000, 16, rd);
		check_state(11'h580, 1'b1, 1'b0);
		wren();
		host.xfer(48'h0100_0000_0000, 16, rd);
		check_state(11'h580, 1'b1, 1'b0);
		@(negedge clk);
		wp_n = 1'b1;
		do_reset();
		check_state(11'h7FF, 1'b0, 1'b0);
		tally_and_finish();
	end
endmodule

`default_nettype wire
